/* design/swpm_pkg.sv */
// Purpose: shared constants and types of the single-wire push-pull master
// Assumes: 32-bit APB, one word per register
// Notes:   all register offsets are byte addresses
package swpm_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int         ADDR_W   = 4;
  localparam logic [3:0] OFF_RATE = 4'h0;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam logic [3:0] OFF_DATA = 4'hC;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int              RATE_W       = 13;
  localparam logic [12:0]     RATE_RST     = 13'h0000;
  localparam int              CTRL_LONG    = 0;
  localparam int              CTRL_RIE     = 5;
  localparam int              ST_BUSY      = 0;
  localparam int              ST_OK        = 1;
  localparam int              ST_FAULT     = 2;
  localparam int              ST_FAIL      = 4;
  localparam int              ST_FULL      = 5;
  localparam logic [7:0]      DATA_RST     = 8'h00;
  // ----------------------------------------
  // timing counts, in time slots and ticks
  // ----------------------------------------
  localparam logic [3:0] TICK_MID       = 4'h7;
  localparam logic [3:0] TICK_LAST      = 4'hF;
  localparam logic [4:0] START_LAST     = 5'h02;
  localparam logic [4:0] PUSH_LAST      = 5'h11;
  localparam logic [4:0] PSYNC_LAST     = 5'h01;
  localparam logic [4:0] PULL_LAST      = 5'h07;
  localparam logic [4:0] LONG_LAST      = 5'h13;
  // ----------------------------------------
  // frame sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_PUSH  = 3'b010,
    ST_PSYNC = 3'b011,
    ST_PULL  = 3'b100,
    ST_EOF   = 3'b101,
    ST_LONG  = 3'b110
  } swpm_state_t;
endpackage

/* design/swpm_slot_if.sv */
// Purpose: carries the slot timing between timer and sequencer
// Assumes: single clock domain
// Notes:   slot_end and mid are one-cycle pulses
interface swpm_slot_if;
  logic [12:0] divisor;
  logic        restart;
  logic        slot_end;
  logic        mid;
  modport timer (input divisor, input restart, output slot_end, output mid);
  modport user  (output divisor, output restart, input slot_end, input mid);
endinterface

/* design/swpm_sync.sv */
// Purpose: two-flop synchroniser for the receive pin
// Assumes: asynchronous input, idle level given by RST_VAL
// Notes:   only the second stage may be read outside
module swpm_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

/* design/swpm_slot_timer.sv */
// Purpose: divides the module clock into ticks and time slots
// Assumes: divisor held stable during a frame
// Notes:   divisor of zero stops all ticks
module swpm_slot_timer (
  input  wire logic  clock,
  input  wire logic  nrst,
  swpm_slot_if.timer slot
);
  import swpm_pkg::*;

  logic [RATE_W-1:0] div_cnt_reg;
  logic [3:0]        tick_cnt_reg;
  wire               run  = (slot.divisor != '0);
  wire               tick = run && (div_cnt_reg == slot.divisor - 13'h0001);

  // ----------------------------------------
  // divider and slot counter
  // ----------------------------------------
  // rate from divisor
  always_ff @(posedge clock) begin
    if (!nrst || slot.restart || !run) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= tick ? '0 : div_cnt_reg + 13'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || slot.restart) begin
      tick_cnt_reg <= 4'h0;
    end else if (tick) begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end
  end

  assign slot.mid      = tick && (tick_cnt_reg == TICK_MID);
  assign slot.slot_end = tick && (tick_cnt_reg == TICK_LAST);
endmodule

/* design/swpm_top.sv */
// Purpose: single-wire push-pull bus master with APB register access
// Assumes: one clock, synchronous active-low reset, zero-wait APB slave
// Notes:   pins are shared with the serial port; no pin direction logic here
//
// Overview of operation
// - each frame opens with three slots of dominant low
// - a Manchester zero sync bit follows the start
// - then five data bits and three address bits, Manchester coded
// - data byte: low five bits data, top three bits slave address
// - two slots after last address bit carry a Manchester one pull sync
// - slave answers NRZ, one bit per slot, stored into data byte
// - push bit spans two slots: zero is high-low, one is low-high
// - frame valid only if code not all ones or zeros and wave follows
// - all ones code and line stuck high marks a failed frame
// - master compares line with sent level during push
// - a push mismatch sets the line fault flag
// - receive path ignores the line during the push field
// - push on transmit pin, pull on receive pin
// - master may start any time (here only while idle; a DATA write while busy is ignored); address picks one of eight slaves
// - slot rate is module clock over sixteen times the divisor; zero stops
// - long low request drives the line low for twenty slots
// - interrupt when receive full and its enable are set
// - status read then data read clears only flags seen set
//
// Local design decisions: the register addresses and the APB slave port.
module swpm_top #(
  parameter int EOF_SLOTS = 4
) (
  input  wire logic                       clock,
  input  wire logic                       nrst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [swpm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            push_out_pin,
  input  wire logic                       pull_in_pin,
  output logic                            irq
);
  import swpm_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  swpm_slot_if slot ();
  swpm_state_t          state_reg, state_next;
  logic [4:0]           slot_cnt_reg, slot_cnt_next;
  logic [RATE_W-1:0]    rate_divisor;
  logic                 rx_irq_enable;
  logic [8:0]           push_seq_reg;
  logic [7:0]           rx_shift_reg;
  logic [7:0]           data_low_byte;
  logic                 rx_full_flag, line_fault_flag;
  logic                 frame_ok_reg, frame_fail_reg;
  logic                 snap_full_reg, snap_fault_reg;
  logic                 prev_s_reg, toggle_reg, low_seen_reg;
  logic                 line_s;
  logic                 drive_next;
  logic [31:0]          rdata_next;

  function automatic logic [4:0] slot_limit(input swpm_state_t s);
    case (s)
      ST_START: slot_limit = START_LAST;
      ST_PUSH:  slot_limit = PUSH_LAST;
      ST_PSYNC: slot_limit = PSYNC_LAST;
      ST_PULL:  slot_limit = PULL_LAST;
      ST_EOF:   slot_limit = 5'(EOF_SLOTS - 1);
      ST_LONG:  slot_limit = LONG_LAST;
      default:  slot_limit = 5'h00;
    endcase
  endfunction

  function automatic logic uniform(input logic [7:0] b, input logic v);
    uniform = (b == {8{v}});
  endfunction

  // ----------------------------------------
  // helpers: timer and receive synchroniser
  // ----------------------------------------
  swpm_slot_timer u_timer (
    .clock (clock),
    .nrst  (nrst),
    .slot  (slot.timer)
  );

  // pull bits read from receive pin
  swpm_sync #(.RST_VAL(1'b1)) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .d     (pull_in_pin),
    .q     (line_s)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire acc      = psel && penable;
  wire setup    = psel && !penable;
  wire hit      = (paddr == OFF_RATE) || (paddr == OFF_CTRL) ||
                  (paddr == OFF_STAT) || (paddr == OFF_DATA);
  wire wr_en    = acc && pwrite && hit;
  wire rd_stat  = acc && !pwrite && (paddr == OFF_STAT);
  wire rd_data  = acc && !pwrite && (paddr == OFF_DATA);
  wire idle     = (state_reg == ST_IDLE);
  // frame may be started whenever the sequencer is free
  wire frame_go = wr_en && (paddr == OFF_DATA) && idle;
  wire long_go  = wr_en && (paddr == OFF_CTRL) && pwdata[CTRL_LONG] && idle;

  assign pready       = 1'b1;
  assign pslverr      = acc && !hit;
  assign slot.divisor = rate_divisor;
  assign slot.restart = frame_go || long_go;

  // ----------------------------------------
  // line events
  // ----------------------------------------
  wire last_slot  = slot.slot_end && (slot_cnt_reg == slot_limit(state_reg));
  wire pushing    = (state_reg == ST_START) || (state_reg == ST_PUSH);
  // compare sent level with line mid slot
  wire fault_set  = slot.mid && pushing && (line_s != push_out_pin);
  // word moves to data byte at pull end
  wire full_set   = last_slot && (state_reg == ST_PULL);
  wire frame_done = last_slot && (state_reg == ST_EOF);
  // valid needs mixed code and square wave
  wire ok_now     = !uniform(data_low_byte, 1'b1) && !uniform(data_low_byte, 1'b0) &&
                    toggle_reg;
  // all ones with line stuck high
  wire fail_now   = uniform(data_low_byte, 1'b1) && !toggle_reg && !low_seen_reg;

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_comb begin
    state_next    = state_reg;
    slot_cnt_next = slot_cnt_reg;
    if (frame_go) begin
      state_next    = ST_START;
      slot_cnt_next = 5'h00;
    end else if (long_go) begin
      state_next    = ST_LONG;
      slot_cnt_next = 5'h00;
    end else if (last_slot) begin
      slot_cnt_next = 5'h00;
      case (state_reg)
        ST_START: state_next = ST_PUSH;
        ST_PUSH:  state_next = ST_PSYNC;
        ST_PSYNC: state_next = ST_PULL;
        ST_PULL:  state_next = ST_EOF;
        default:  state_next = ST_IDLE;
      endcase
    end else if (slot.slot_end) begin
      slot_cnt_next = slot_cnt_reg + 5'h01;
    end
  end

  // first half is the complement, second the bit
  always_comb begin
    case (state_reg)
      ST_START: drive_next = 1'b0;
      ST_PUSH:  drive_next = push_seq_reg[slot_cnt_reg[4:1]] ^ ~slot_cnt_reg[0];
      ST_PSYNC: drive_next = slot_cnt_reg[0];
      ST_LONG:  drive_next = 1'b0;
      default:  drive_next = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg    <= ST_IDLE;
      slot_cnt_reg <= 5'h00;
      push_out_pin <= 1'b1;
    end else begin
      state_reg    <= state_next;
      slot_cnt_reg <= slot_cnt_next;
      push_out_pin <= drive_next;
    end
  end

  // sync zero sent ahead of the byte
  always_ff @(posedge clock) begin
    if (!nrst) begin
      push_seq_reg <= 9'h000;
    end else if (frame_go) begin
      push_seq_reg <= {pwdata[7:0], 1'b0};
    end
  end

  // ----------------------------------------
  // pull receive and end-of-frame check
  // ----------------------------------------
  // shifter only listens during the pull data
  // NRZ bits, first one into bit 0
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rx_shift_reg <= 8'h00;
    end else if (slot.mid && (state_reg == ST_PULL)) begin
      rx_shift_reg <= {line_s, rx_shift_reg[7:1]};
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_low_byte <= DATA_RST;
    end else if (full_set) begin
      data_low_byte <= rx_shift_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || frame_go) begin
      prev_s_reg   <= 1'b1;
      toggle_reg   <= 1'b0;
      low_seen_reg <= 1'b0;
    end else if (slot.mid && (state_reg == ST_EOF)) begin
      prev_s_reg   <= line_s;
      toggle_reg   <= toggle_reg || (line_s != prev_s_reg);
      low_seen_reg <= low_seen_reg || !line_s;
    end else if (slot.mid && (state_reg == ST_PULL)) begin
      prev_s_reg   <= line_s;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || frame_go) begin
      frame_ok_reg   <= 1'b0;
      frame_fail_reg <= 1'b0;
    end else if (frame_done) begin
      frame_ok_reg   <= ok_now;
      frame_fail_reg <= fail_now;
    end
  end

  // ----------------------------------------
  // registers and flags
  // ----------------------------------------
  // divisor programmed by software
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rate_divisor  <= RATE_RST;
      rx_irq_enable <= 1'b0;
    end else if (wr_en && (paddr == OFF_RATE)) begin
      rate_divisor  <= pwdata[RATE_W-1:0];
    end else if (wr_en && (paddr == OFF_CTRL)) begin
      rx_irq_enable <= pwdata[CTRL_RIE];
    end
  end

  // snapshot of flags seen at status read
  always_ff @(posedge clock) begin
    if (!nrst || rd_data) begin
      snap_full_reg  <= 1'b0;
      snap_fault_reg <= 1'b0;
    end else if (rd_stat) begin
      snap_full_reg  <= prdata[ST_FULL];
      snap_fault_reg <= prdata[ST_FAULT];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rx_full_flag    <= 1'b0;
      line_fault_flag <= 1'b0;
    end else begin
      rx_full_flag    <= full_set || (rx_full_flag && !(rd_data && snap_full_reg));
      line_fault_flag <= fault_set || (line_fault_flag && !(rd_data && snap_fault_reg));
    end
  end

  // read data captured in setup so it comes from a flop
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      OFF_RATE: rdata_next[RATE_W-1:0] = rate_divisor;
      OFF_CTRL: rdata_next[CTRL_RIE]   = rx_irq_enable;
      OFF_STAT: begin
        rdata_next[ST_BUSY]  = !idle;
        rdata_next[ST_OK]    = frame_ok_reg;
        rdata_next[ST_FAULT] = line_fault_flag;
        rdata_next[ST_FAIL]  = frame_fail_reg;
        rdata_next[ST_FULL]  = rx_full_flag;
      end
      OFF_DATA: rdata_next[7:0] = data_low_byte;
      default:  rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= rdata_next;
    end
  end

  assign irq = rx_full_flag && rx_irq_enable;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_start_low;
    (state_reg == ST_START) |=> !push_out_pin;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start slot not low");

  property p_start_three;
    (state_reg == ST_START) && slot.slot_end && (slot_cnt_reg == 5'h02) |=>
      (state_reg == ST_PUSH) && (slot_cnt_reg == 5'h00);
  endproperty
  a_start_three: assert property (p_start_three) else $error("start not three slots");

  property p_sync_zero;
    (state_reg == ST_PUSH) && (slot_cnt_reg == 5'h00) |=> push_out_pin;
  endproperty
  a_sync_zero: assert property (p_sync_zero) else $error("sync bit first half not high");

  property p_push_len;
    (state_reg == ST_PUSH) && slot.slot_end && (slot_cnt_reg == 5'h11) |=>
      (state_reg == ST_PSYNC);
  endproperty
  a_push_len: assert property (p_push_len) else $error("push field not eighteen slots");

  property p_load_byte;
    frame_go |=> (push_seq_reg == {$past(pwdata[7:0]), 1'b0});
  endproperty
  a_load_byte: assert property (p_load_byte) else $error("push byte not loaded");

  property p_pull_sync;
    (state_reg == ST_PSYNC) |=> (push_out_pin == $past(slot_cnt_reg[0]));
  endproperty
  a_pull_sync: assert property (p_pull_sync) else $error("pull sync not low-high");

  property p_fault;
    fault_set |=> line_fault_flag;
  endproperty
  a_fault: assert property (p_fault) else $error("bit error lost");

  property p_no_rx_push;
    pushing |=> $stable(rx_shift_reg);
  endproperty
  a_no_rx_push: assert property (p_no_rx_push) else $error("receiver moved in push");

  property p_long_low;
    (state_reg == ST_LONG) |=> !push_out_pin;
  endproperty
  a_long_low: assert property (p_long_low) else $error("long low released");

  property p_full;
    full_set |=> rx_full_flag && (data_low_byte == $past(rx_shift_reg));
  endproperty
  a_full: assert property (p_full) else $error("pull word not stored");

  property p_clear;
    rd_data && snap_full_reg && !full_set |=> !rx_full_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("receive full not cleared");

  c_frame: cover property (frame_done && ok_now);
  c_fail:  cover property (frame_done && fail_now);
  c_fault: cover property (fault_set);
  c_long:  cover property ((state_reg == ST_LONG) && last_slot);
endmodule

/* tb/swpm_slave_model.sv */
// Purpose: behavioural slave device on the single wire
// Assumes: slot length fixed by SLOT, pull-up on the wire
// Notes:   mode 0 answers, 1 reports failure, 2 also clamps the push field
module swpm_slave_model #(
  parameter int SLOT      = 16,
  parameter int EOF_SLOTS = 4
) (
  input  wire logic       clock,
  input  wire logic       push_out_pin,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] resp,
  output logic            pull_in_pin,
  output logic [7:0]      got_byte,
  output logic            shape_ok,
  output int              frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        slave_low;
  logic [22:0] lv;
  logic        noisy;
  // pull-up: low while either party pulls
  assign pull_in_pin = push_out_pin & ~slave_low;

  initial begin
    slave_low = 1'b0;
    got_byte  = 8'h00;
    shape_ok  = 1'b0;
    frames    = 0;
    forever begin
      @(negedge push_out_pin);
      noisy = 1'b0;
      repeat (SLOT / 2) @(posedge clock);
      for (int s = 0; s < 23; s++) begin
        lv[s] = push_out_pin;
        if (mode == 2'h2) slave_low <= (s == 2 || s == 3);
        if (s == 3 && push_out_pin === 1'b0) break;
        repeat (SLOT / 4) @(posedge clock);
        if (push_out_pin !== lv[s]) noisy = 1'b1;
        if (s < 22) repeat (SLOT - SLOT / 4) @(posedge clock);
      end
      if (lv[3] === 1'b0) begin
        // long low, no frame follows
        @(posedge push_out_pin);
      end else begin
        shape_ok <= !noisy && (lv[2:0] == 3'h0) && (lv[4:3] == 2'h1) &&
                    (lv[22:21] == 2'h2);
        for (int j = 0; j < 8; j++) begin
          got_byte[j] <= lv[6 + 2 * j];
          if (lv[5 + 2 * j] == lv[6 + 2 * j]) shape_ok <= 1'b0;
        end
        frames <= frames + 1;
        repeat (SLOT / 2 - SLOT / 4) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
          slave_low <= ~resp[i];
          repeat (SLOT) @(posedge clock);
        end
        for (int i = 0; i < EOF_SLOTS; i++) begin
          slave_low <= (mode != 2'h1) && !i[0];
          repeat (SLOT) @(posedge clock);
        end
        slave_low <= 1'b0;
      end
    end
  end
endmodule

/* tb/testbench.sv */
// Purpose: self-checking bench for the single-wire push-pull master
// Assumes: rate divisor written as 1, so one slot is 16 clocks
// Notes:   frames are judged by the slave model and the status word
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import swpm_pkg::*;
  localparam int SLOT = 16;
  logic              clock;
  logic              nrst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              push_out_pin;
  logic              pull_in_pin;
  logic              irq;
  logic [1:0]        mode;
  logic [7:0]        resp;
  logic [7:0]        got_byte;
  logic              shape_ok;
  int                frames;
  int                fail_count;
  int                compares;
  logic [31:0]       rd;
  logic              err;

  swpm_top #(.EOF_SLOTS(4)) DUT (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .push_out_pin(push_out_pin), .pull_in_pin(pull_in_pin),
    .irq(irq)
  );
  swpm_slave_model #(.SLOT(SLOT), .EOF_SLOTS(4)) slave (
    .clock(clock), .push_out_pin(push_out_pin), .mode(mode), .resp(resp),
    .pull_in_pin(pull_in_pin), .got_byte(got_byte), .shape_ok(shape_ok),
    .frames(frames)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report();
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      final_report();
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0000_0000);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 400);
    if (rd[ST_BUSY] !== 1'b0) begin
      fail_count++;
      final_report();
    end
  endtask

  task automatic do_frame(input logic [7:0] b, input logic [1:0] m, input logic [7:0] r);
    mode <= m;
    resp <= r;
    apb(1'b1, OFF_DATA, {24'h00_0000, b});
    wait_idle();
  endtask

  // status read then data read must clear full and fault
  task automatic clear_flags(input logic [7:0] exp);
    apb(1'b0, OFF_STAT, 32'h0000_0000);
    apb(1'b0, OFF_DATA, 32'h0000_0000);
    check(rd, {24'h00_0000, exp});
    apb(1'b0, OFF_STAT, 32'h0000_0000);
    check(rd & 32'h0000_0024, 32'h0000_0000);
    check({31'h0000_0000, irq}, 32'h0000_0000);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({31'h0000_0000, push_out_pin}, 32'h0000_0001);
    apb(1'b0, OFF_RATE, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, OFF_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 4'h6, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, OFF_RATE, 32'hFFFF_FFFF);
    apb(1'b0, OFF_RATE, 32'h0000_0000);
    check(rd, 32'h0000_1FFF);
    apb(1'b1, OFF_RATE, 32'h0000_0001);
  endtask

  task automatic t_frame_ok();
    apb(1'b1, OFF_CTRL, 32'h0000_0020);
    mode <= 2'h0;
    resp <= 8'h5A;
    apb(1'b1, OFF_DATA, 32'h0000_00A5);
    apb(1'b1, OFF_DATA, 32'h0000_003C);
    wait_idle();
    check(rd, 32'h0000_0022);
    check({24'h00_0000, got_byte}, 32'h0000_00A5);
    check({31'h0000_0000, shape_ok}, 32'h0000_0001);
    check(frames, 1);
    check({31'h0000_0000, irq}, 32'h0000_0001);
    clear_flags(8'h5A);
  endtask

  task automatic t_frame_fail();
    do_frame(8'hE1, 2'h1, 8'hFF);
    check(rd, 32'h0000_0030);
    check({24'h00_0000, got_byte}, 32'h0000_00E1);
    clear_flags(8'hFF);
  endtask

  task automatic t_code_zero();
    do_frame(8'h1F, 2'h0, 8'h00);
    check(rd, 32'h0000_0020);
    check({31'h0000_0000, shape_ok}, 32'h0000_0001);
    clear_flags(8'h00);
  endtask

  task automatic t_bit_error();
    do_frame(8'h42, 2'h2, 8'h96);
    check(rd, 32'h0000_0026);
    check({24'h00_0000, got_byte}, 32'h0000_0042);
    clear_flags(8'h96);
    mode <= 2'h0;
  endtask

  task automatic t_long_low();
    int n;
    int low;
    apb(1'b1, OFF_CTRL, 32'h0000_0021);
    n = 0;
    while (push_out_pin !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    low = 0;
    while (push_out_pin === 1'b0 && low < 1000) begin
      @(posedge clock);
      low++;
    end
    check(low, 20 * SLOT);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0020);
    check(frames, 4);
  endtask

  // ----------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    nrst       = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = 32'h0000_0000;
    mode       = 2'h0;
    resp       = 8'h00;
    fail_count = 0;
    compares   = 0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_frame_ok();
    t_frame_fail();
    t_code_zero();
    t_bit_error();
    t_long_low();
    final_report();
  end
endmodule
